// File: core/bcb_pkg.sv
// constants for the channel b break condition qualifier
package bcb_pkg;
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 16;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_VALUE = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_SELECT = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;
    // reset values
    localparam logic [31:0] RST_VALUE = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    // selector field positions (low bit of each two-bit field)
    localparam int SEL_MASTER_LO = 6;
    localparam int SEL_ACCESS_LO = 4;
    localparam int SEL_DIR_LO = 2;
    localparam int SEL_SIZE_LO = 0;
    // implemented selector width; bits above read as zero
    localparam int SEL_IMPL_W = 8;
    // control register: data compare enable position
    localparam int CTL_DATA_EN_BIT = 7;
    // status / interrupt mask layout
    localparam int ST_CPU_BIT = 0;
    localparam int ST_DMA_BIT = 1;
    // two-bit field codes
    localparam logic [1:0] FLD_OFF = 2'h0;
    localparam logic [1:0] FLD_A = 2'h1;
    localparam logic [1:0] FLD_B = 2'h2;
    localparam logic [1:0] FLD_BOTH = 2'h3;
    // operand size codes on the watched bus
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
endpackage

// File: core/bcb_top.sv
// channel b break condition qualifier: data compare plus bus cycle selector
//
// Overview of operation
// - 32-bit break data value, resets to zero
// - 32-bit break data mask, resets to zero
// - mask bit 1 excludes that bit
// - 16-bit cycle selector, resets to zero
// - selector bits 15..8 read zero
// - master field: off, cpu, dma
// - access field: off, fetch, data, either
// - direction field: off, read, write, both
// - size field: any, byte, word, long
// - data compare only when enable bit set
//
// register map, one 32-bit word per offset, whole words only:
// value, mask, cycle selector, control, status, interrupt mask
// the selector keeps only its low byte; the upper byte has no flops,
// so a write there is dropped and a read always returns zero
// status flags are sticky and cleared by writing ones to them
// the data compare runs over all 32 bits whatever the size field says;
// keeping the byte lanes consistent is left to software, which saves
// a lane selector in front of the compare
// every qualifier field of 00 is simply not checked
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module bcb_top
    import bcb_pkg::*;
(
    input wire logic mclk_in, // system clock, 50 mhz
    input wire logic rst_b_in, // power-on reset, active low
    // register port
    input wire logic [bcb_pkg::ADDR_W-1:0] reg_addr_in, // byte address
    input wire logic [bcb_pkg::DATA_W-1:0] reg_wdata_in, // write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [bcb_pkg::DATA_W-1:0] reg_rdata_out, // read data, next cycle
    // watched internal bus cycle
    input wire logic bus_valid_in, // one cycle per bus access
    input wire logic bus_dma_in, // 1 dma master, 0 cpu
    input wire logic bus_fetch_in, // 1 instruction fetch, 0 data
    input wire logic bus_write_in, // 1 write, 0 read
    input wire logic [1:0] bus_size_in, // 01 byte, 10 word, 11 long
    input wire logic [bcb_pkg::DATA_W-1:0] bus_data_in, // data bus value
    // results
    output logic match_out, // one-cycle pulse on a hit
    output logic match_dma_out, // master of the hit, 1 dma
    output logic irq_out // level, unmasked flag set
);
    import bcb_pkg::*;

    // registers seen by software
    logic [DATA_W-1:0] value_reg; // compare value
    logic [DATA_W-1:0] mask_reg; // compare mask
    logic [SEL_IMPL_W-1:0] select_reg; // cycle selector, low byte
    logic data_en_reg; // data compare enable
    logic [1:0] status_reg; // sticky hit flags
    logic [1:0] status_next; // flags after this cycle
    logic [1:0] int_mask_reg; // interrupt enables
    logic [1:0] int_mask_next; // enables after this cycle
    // output flops
    logic [DATA_W-1:0] rdata_reg; // read data
    logic match_reg; // hit pulse
    logic match_dma_reg; // hit master
    logic irq_reg; // interrupt level
    // decode terms
    logic wr_value; // write to value
    logic wr_mask; // write to mask
    logic wr_select; // write to selector
    logic wr_control; // write to control
    logic wr_status; // write-one-to-clear status
    logic wr_int_mask; // write to interrupt mask
    // condition terms
    logic hit_master; // master qualifier met
    logic hit_access; // access type qualifier met
    logic hit_dir; // direction qualifier met
    logic hit_size; // size qualifier met
    logic hit_data; // data qualifier met
    logic hit; // complete condition this cycle
    logic [1:0] hit_flags; // per-master event bits

    // two-bit field where 00 means the qualifier is not checked;
    // 01 selects side a, 10 side b, 11 either side
    function automatic logic pair_hit(
        input logic [1:0] fld,
        input logic side_a,
        input logic side_b
    );
        logic res;
        res = 1'b1;
        case (fld)
            FLD_OFF: res = 1'b1; // not compared
            FLD_A: res = side_a;
            FLD_B: res = side_b;
            FLD_BOTH: res = side_a | side_b;
            default: res = 1'b1;
        endcase
        return res;
    endfunction

    // two-bit field picked out of the selector
    function automatic logic [1:0] sel_field(
        input logic [SEL_IMPL_W-1:0] sel,
        input int lo
    );
        logic [1:0] f;
        f = sel[lo +: 2];
        return f;
    endfunction

    // address decode for writes
    always_comb
    begin
        wr_value = reg_wr_in && (reg_addr_in == OFF_VALUE);
        wr_mask = reg_wr_in && (reg_addr_in == OFF_MASK);
        wr_select = reg_wr_in && (reg_addr_in == OFF_SELECT);
        wr_control = reg_wr_in && (reg_addr_in == OFF_CONTROL);
        wr_status = reg_wr_in && (reg_addr_in == OFF_STATUS);
        wr_int_mask = reg_wr_in && (reg_addr_in == OFF_INT_MASK);
    end

    // compare value register
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            value_reg <= RST_VALUE;
        end
        else if (wr_value)
        begin
            value_reg <= reg_wdata_in;
        end
    end

    // compare mask register
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mask_reg <= RST_MASK;
        end
        else if (wr_mask)
        begin
            mask_reg <= reg_wdata_in;
        end
    end

    // selector: only the low byte is stored, the upper byte has no flops
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            select_reg <= RST_SELECT;
        end
        else if (wr_select)
        begin
            select_reg <= reg_wdata_in[SEL_IMPL_W-1:0];
        end
    end

    // control: data compare enable
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            data_en_reg <= 1'b0;
        end
        else if (wr_control)
        begin
            data_en_reg <= reg_wdata_in[CTL_DATA_EN_BIT];
        end
    end

    // interrupt mask
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            int_mask_reg <= RST_FLAGS;
        end
        else if (wr_int_mask)
        begin
            int_mask_reg <= reg_wdata_in[1:0];
        end
    end

    // interrupt enables after this cycle, so a mask write and the level
    // it implies land on the same edge, as the status flags do
    always_comb
    begin
        int_mask_next = int_mask_reg;
        if (wr_int_mask)
        begin
            int_mask_next = reg_wdata_in[1:0];
        end
    end

    // cycle qualifiers; bus inputs come from logic on this clock
    // no synchronisers here: the watched bus shares this clock, and extra
    // flops would shift every match by a cycle against its bus cycle
    always_comb
    begin
        // x1 selects cpu, 10 selects dma
        case (sel_field(select_reg, SEL_MASTER_LO))
            FLD_OFF: hit_master = 1'b1;
            FLD_B: hit_master = bus_dma_in;
            default: hit_master = !bus_dma_in;
        endcase
        hit_access = pair_hit(sel_field(select_reg, SEL_ACCESS_LO),
                              bus_fetch_in, !bus_fetch_in);
        hit_dir = pair_hit(sel_field(select_reg, SEL_DIR_LO),
                           !bus_write_in, bus_write_in);
        // 00 ignores size, otherwise the code must equal the access size
        if (sel_field(select_reg, SEL_SIZE_LO) == FLD_OFF)
        begin
            hit_size = 1'b1;
        end
        else
        begin
            hit_size = (sel_field(select_reg, SEL_SIZE_LO) == bus_size_in);
        end
    end

    // data qualifier: masked bits are forced equal; software keeps a
    // size selected and the byte replicated, the compare does not check that
    // a set mask bit always agrees, so an all-ones mask passes any data
    always_comb
    begin
        if (data_en_reg)
        begin
            hit_data = &(~(value_reg ^ bus_data_in) | mask_reg);
        end
        else
        begin
            hit_data = 1'b1;
        end
    end

    // full condition and the event it raises
    always_comb
    begin
        hit = bus_valid_in && hit_master && hit_access
              && hit_dir && hit_size && hit_data;
        hit_flags = 2'b00;
        hit_flags[ST_CPU_BIT] = hit && !bus_dma_in;
        hit_flags[ST_DMA_BIT] = hit && bus_dma_in;
    end

    // a clear racing a new hit must not lose the hit, or a break is hidden
    // sticky flags: a new hit wins over a write-one clear in the same cycle
    always_comb
    begin
        status_next = status_reg;
        if (wr_status)
        begin
            status_next = status_reg & ~reg_wdata_in[1:0];
        end
        status_next = status_next | hit_flags;
    end

    // status register
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            status_reg <= RST_FLAGS;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // interrupt level follows the flags with no extra cycle of delay
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(status_next & int_mask_next);
        end
    end

    // hit pulse, one cycle after the bus cycle
    // the master flag is gated by the hit so it never stands alone
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            match_reg <= 1'b0;
            match_dma_reg <= 1'b0;
        end
        else
        begin
            match_reg <= hit;
            match_dma_reg <= hit && bus_dma_in;
        end
    end

    // read data; unmapped or idle cycles return zero
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_reg <= '0;
        end
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                OFF_VALUE: rdata_reg <= value_reg;
                OFF_MASK: rdata_reg <= mask_reg;
                // upper selector bits have no storage and read zero
                OFF_SELECT: rdata_reg <= {24'h00_0000, select_reg};
                OFF_CONTROL: rdata_reg <= {24'h00_0000, data_en_reg, 7'h00};
                OFF_STATUS: rdata_reg <= {30'h0000_0000, status_reg};
                OFF_INT_MASK: rdata_reg <= {30'h0000_0000, int_mask_reg};
                default: rdata_reg <= '0;
            endcase
        end
        else
        begin
            // data stands only in the cycle after the strobe
            rdata_reg <= '0;
        end
    end

    // outputs come straight from flops
    assign reg_rdata_out = rdata_reg;
    assign match_out = match_reg;
    assign match_dma_out = match_dma_reg;
    assign irq_out = irq_reg;

endmodule

`default_nettype wire

// File: verif/bcb_bus_model.sv
// bus cycle source standing in for the processor and dma master
`timescale 1ns/10ps
`default_nettype none
module bcb_bus_model (
    input wire logic clk_in, // clock
    output logic valid_out, // cycle present
    output logic dma_out, // dma master
    output logic fetch_out, // fetch
    output logic write_out, // write
    output logic [1:0] size_out, // size
    output logic [31:0] data_out // data
);
    initial {valid_out, dma_out, fetch_out, write_out, size_out, data_out} = '0;
    // one cycle, held across its sampling edge
    task automatic cycle(input logic dm, f, w, input logic [1:0] z, input logic [31:0] d);
        valid_out <= 1'b1;
        {dma_out, fetch_out, write_out, size_out, data_out} <= {dm, f, w, z, d};
        @(posedge clk_in);
    endtask
    // released bus shows the inverse of the last data, so no stale match
    task automatic idle(input int n);
        valid_out <= 1'b0;
        data_out <= ~data_out;
        repeat (n + 1) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: verif/bcb_top_assertions.sv
// port checks for the channel b break condition qualifier
`timescale 1ns/10ps
`default_nettype none
module bcb_top_assertions
    import bcb_pkg::*;
(
    input wire logic mclk_in, // clock
    input wire logic rst_b_in, // reset, active low
    input wire logic [ADDR_W-1:0] reg_addr_in, // address
    input wire logic [DATA_W-1:0] reg_wdata_in, // write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata_out, // read data
    input wire logic bus_valid_in, // bus cycle
    input wire logic bus_dma_in, // dma master
    input wire logic match_out, // hit pulse
    input wire logic match_dma_out, // hit master
    input wire logic irq_out // interrupt
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // a read right after a write returns the written word
    property p_value_rb;
        reg_wr_in && reg_addr_in == OFF_VALUE ##1 reg_rd_in && reg_addr_in == OFF_VALUE
        |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_value_rb: assert property (p_value_rb) else $error("value readback wrong");
    // only the low selector byte is kept
    property p_sel_rb;
        reg_wr_in && reg_addr_in == OFF_SELECT ##1 reg_rd_in && reg_addr_in == OFF_SELECT
        |=> reg_rdata_out == {24'h0, $past(reg_wdata_in[7:0], 2)};
    endproperty
    a_sel_rb: assert property (p_sel_rb) else $error("selector readback wrong");
    property p_sel_hi;
        reg_rd_in && reg_addr_in == OFF_SELECT |=> reg_rdata_out[31:8] == 24'h0;
    endproperty
    a_sel_hi: assert property (p_sel_hi) else $error("selector upper bits set");
    // a hit pulse always has a bus cycle one edge before
    property p_hit_cause;
        match_out |-> $past(bus_valid_in);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without bus cycle");
    property p_idle;
        !bus_valid_in |=> !match_out;
    endproperty
    a_idle: assert property (p_idle) else $error("hit on idle bus");
    property p_hit_master;
        match_out |-> match_dma_out == $past(bus_dma_in);
    endproperty
    a_hit_master: assert property (p_hit_master) else $error("hit master wrong");
    property p_dma_zero;
        !match_out |-> !match_dma_out;
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("master flag without hit");
    // sticky status keeps the level up until software writes
    property p_irq_sticky;
        irq_out && !reg_wr_in |=> irq_out;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped");
endmodule
`default_nettype wire

// File: verif/break_channel_b_condition_tb.sv
// self-checking bench for the channel b break condition qualifier
`timescale 1ns/10ps
`default_nettype none
module break_channel_b_condition_tb;
    import bcb_pkg::*;
    logic mclk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, bus_data_in;
    logic bus_valid_in, bus_dma_in, bus_fetch_in, bus_write_in, match_out, match_dma_out, irq_out;
    logic [1:0] bus_size_in;
    logic [31:0] rq[$]; // expected read words
    logic [1:0] mq[$]; // expected hit and master
    logic rd_d = 1'b0, bv_d = 1'b0; // strobes seen at the previous edge
    int err_total = 0, total_checks = 0, cyc = 0, seed = 48201;
    always #10 mclk_in = ~mclk_in;
    bcb_top dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .bus_valid_in(bus_valid_in), .bus_dma_in(bus_dma_in),
        .bus_fetch_in(bus_fetch_in), .bus_write_in(bus_write_in), .bus_size_in(bus_size_in),
        .bus_data_in(bus_data_in), .match_out(match_out), .match_dma_out(match_dma_out),
        .irq_out(irq_out));
    bcb_bus_model bm (.clk_in(mclk_in), .valid_out(bus_valid_in), .dma_out(bus_dma_in),
        .fetch_out(bus_fetch_in), .write_out(bus_write_in), .size_out(bus_size_in),
        .data_out(bus_data_in));
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one register access; a read notes its expected word
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {w, !w, a, d};
        if (!w)
            rq.push_back(d);
        @(posedge mclk_in);
    endtask
    task automatic quiet();
        {reg_wr_in, reg_rd_in} <= 2'b00;
        @(posedge mclk_in);
    endtask
    // reference qualifier worked out from the selector codes
    function automatic logic exp_hit(input logic [7:0] s, input logic e, input logic [31:0] v,
        input logic [31:0] m, input logic dm, f, w, input logic [1:0] z, input logic [31:0] d);
        exp_hit = (s[7:6] == 2'h0 || (s[6] ? !dm : dm))
            && (s[5:4] == 2'h0 || s[5:4] == 2'h3 || s[4] == f)
            && (s[3:2] == 2'h0 || s[3:2] == 2'h3 || s[3] == w)
            && (s[1:0] == 2'h0 || s[1:0] == z)
            && (!e || ((d ^ v) & ~m) == 32'h0);
    endfunction
    // scoreboard: each result against the oldest note, plus the run limit
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
        if (rd_d)
            chk_word(reg_rdata_out, rq.pop_front());
        if (bv_d)
        begin
            chk_bit(match_out, mq[0][1]);
            chk_bit(match_dma_out, mq[0][0]);
            void'(mq.pop_front());
        end
        rd_d <= reg_rd_in;
        bv_d <= bus_valid_in;
    end
    initial
    begin
        logic [7:0] s;
        logic e, h;
        logic [31:0] v, m, d, r;
        logic [1:0] z;
        repeat (4) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(posedge mclk_in);
        acc(0, OFF_VALUE, 32'h0);
        acc(0, OFF_MASK, 32'h0);
        acc(0, OFF_SELECT, 32'h0);
        acc(1, OFF_SELECT, 32'hffff_ffff);
        acc(0, OFF_SELECT, 32'h0000_00ff);
        acc(0, 8'h40, 32'h0);
        for (int i = 0; i < 64; i++)
        begin
            r = $random(seed);
            {s, e} = {r[7:0], r[8]};
            v = $random(seed);
            m = $random(seed);
            if (e && s[1:0] == 2'h0)
                s[1:0] = SZ_LONG;
            if (s[1:0] == SZ_BYTE)
                v[15:8] = v[7:0];
            acc(1, OFF_VALUE, v);
            acc(0, OFF_VALUE, v);
            acc(1, OFF_MASK, m);
            acc(0, OFF_MASK, m);
            acc(1, OFF_SELECT, {24'h0, s});
            acc(0, OFF_SELECT, {24'h0, s});
            acc(1, OFF_CONTROL, {24'h0, e, 7'h0});
            acc(0, OFF_CONTROL, {24'h0, e, 7'h0});
            quiet();
            repeat (4)
            begin
                r = $random(seed);
                z = (r[1:0] == 2'h0) ? SZ_LONG : r[1:0];
                d = r[2] ? v ^ (r & m) : r;
                h = exp_hit(s, e, v, m, r[3], r[4], r[5], z, d);
                mq.push_back({h, h & r[3]});
                bm.cycle(r[3], r[4], r[5], z, d);
            end
            bm.idle(i % 3);
        end
        // interrupt: masked hit, unmask, write-one clear
        acc(1, OFF_INT_MASK, 32'h0);
        acc(1, OFF_STATUS, 32'h3);
        acc(1, OFF_SELECT, 32'h0);
        acc(1, OFF_CONTROL, 32'h0);
        acc(0, OFF_STATUS, 32'h0);
        quiet();
        mq.push_back(2'h3);
        bm.cycle(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h0);
        bm.idle(1);
        chk_bit(irq_out, 1'b0);
        acc(0, OFF_STATUS, 32'h2);
        acc(1, OFF_INT_MASK, 32'h2);
        quiet();
        quiet();
        chk_bit(irq_out, 1'b1);
        acc(1, OFF_STATUS, 32'h2);
        quiet();
        quiet();
        chk_bit(irq_out, 1'b0);
        acc(0, OFF_STATUS, 32'h0);
        quiet();
        quiet();
        tally_and_finish();
    end
endmodule
bind bcb_top bcb_top_assertions chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .bus_valid_in(bus_valid_in),
    .bus_dma_in(bus_dma_in), .match_out(match_out), .match_dma_out(match_dma_out),
    .irq_out(irq_out));
`default_nettype wire
